// ### rtl/switch_queue_priority_config.sv
// Purpose: global queue priority configuration bank and per-frame decision
// Assumes: frame descriptors come from logic on clk_sys
// Notes: one-cycle registered decision per frame, waitrequest bus slave
`timescale 1ns/1ps
module switch_queue_priority_config #(
    parameter int NUM_PORTS = qcfg_pkg::PORTS
) (
    // clock and reset
    input  wire logic                     clk_sys,
    input  wire logic                     arst_n,
    // avalon-mm slave
    input  wire logic [11:0]              avs_address,
    input  wire logic                     avs_read,
    input  wire logic                     avs_write,
    input  wire logic [31:0]              avs_writedata,
    input  wire logic [3:0]               avs_byteenable,
    output logic      [31:0]              avs_readdata,
    output logic                          avs_waitrequest,
    // frame decision
    input  wire qcfg_pkg::frame_in_t      frame_in,
    output qcfg_pkg::frame_out_t          frame_out,
    // configuration seen by the queue and colour logic
    output logic      [5:0]               colour_dscp
);

    // the frame carriers are sized by the package, so the port count cannot move alone
    if (NUM_PORTS != qcfg_pkg::PORTS) begin : g_bad_ports
        $error("port count must match the frame carrier width");
    end

    ////////////////////////////////////////////////////////////////////////////////
    logic [1:0] red_r, yellow_r, green_r;
    logic       ev_ovr_r, ne_ovr_r;
    logic [3:0] ev_prio_r, ne_prio_r;
    logic [1:0] fold_r;
    logic [3:0] qres_r;
    logic       disc_r, q0res_r;
    logic       ack_r;
    logic [11:0] idx;
    logic       acc, wr_go, rd_go, hit;
    logic [31:0] rd_nxt;

    // one wait cycle: every access ends at the second edge
    assign acc   = avs_read | avs_write;
    assign wr_go = avs_write & ack_r;
    assign rd_go = avs_read & ack_r;
    assign idx   = avs_address;
    assign hit   = (idx == qcfg_pkg::IDX_COLOUR) | (idx == qcfg_pkg::IDX_EVENT)
                 | (idx == qcfg_pkg::IDX_NONEVENT) | (idx == qcfg_pkg::IDX_QMGMT);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= acc & ~ack_r;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= ~(acc & ~ack_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // writes: 8-bit registers use lane 0 only
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            red_r    <= qcfg_pkg::RED_RST;
            yellow_r <= qcfg_pkg::YELLOW_RST;
            green_r  <= qcfg_pkg::GREEN_RST;
        end else if (wr_go && idx == qcfg_pkg::IDX_COLOUR && avs_byteenable[0]) begin
            red_r    <= avs_writedata[qcfg_pkg::RED_LSB +: 2];
            yellow_r <= avs_writedata[qcfg_pkg::YELLOW_LSB +: 2];
            green_r  <= avs_writedata[qcfg_pkg::GREEN_LSB +: 2];
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ev_ovr_r  <= qcfg_pkg::OVR_RST;
            ev_prio_r <= qcfg_pkg::PRIO_RST;
        end else if (wr_go && idx == qcfg_pkg::IDX_EVENT && avs_byteenable[0]) begin
            ev_ovr_r  <= avs_writedata[qcfg_pkg::OVR_BIT];
            ev_prio_r <= avs_writedata[3:0];
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ne_ovr_r  <= qcfg_pkg::OVR_RST;
            ne_prio_r <= qcfg_pkg::PRIO_RST;
        end else if (wr_go && idx == qcfg_pkg::IDX_NONEVENT && avs_byteenable[0]) begin
            ne_ovr_r  <= avs_writedata[qcfg_pkg::OVR_BIT];
            ne_prio_r <= avs_writedata[3:0];
        end
    end

    // reserved 5:2 and 0 are writable storage here
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            fold_r  <= qcfg_pkg::FOLD_RST;
            qres_r  <= qcfg_pkg::QRES_RST;
            disc_r  <= qcfg_pkg::DISC_RST;
            q0res_r <= qcfg_pkg::Q0RES_RST;
        end else if (wr_go && idx == qcfg_pkg::IDX_QMGMT && avs_byteenable[0]) begin
            fold_r  <= avs_writedata[qcfg_pkg::FOLD_LSB +: 2];
            qres_r  <= avs_writedata[5:2];
            disc_r  <= avs_writedata[qcfg_pkg::DISC_BIT];
            q0res_r <= avs_writedata[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        rd_nxt = 32'h0000_0000;
        unique case (idx)
            qcfg_pkg::IDX_COLOUR:   rd_nxt = {26'h0, red_r, yellow_r, green_r};
            qcfg_pkg::IDX_EVENT:    rd_nxt = {24'h0, ev_ovr_r, 3'h0, ev_prio_r};
            qcfg_pkg::IDX_NONEVENT: rd_nxt = {24'h0, ne_ovr_r, 3'h0, ne_prio_r};
            qcfg_pkg::IDX_QMGMT:    rd_nxt = {24'h0, fold_r, qres_r, disc_r, q0res_r};
            default:                rd_nxt = 32'h0000_0000;
        endcase
    end

    // unmapped addresses read zero and swallow writes
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !ack_r) begin
            avs_readdata <= hit ? rd_nxt : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            colour_dscp <= {qcfg_pkg::RED_RST, qcfg_pkg::YELLOW_RST, qcfg_pkg::GREEN_RST};
        end else begin
            colour_dscp <= {red_r, yellow_r, green_r};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    logic [3:0]               prio_nxt;
    logic                     high_nxt;
    logic                     single;
    logic [NUM_PORTS-1:0]     fwd_nxt;
    logic                     drop_nxt;

    always_comb begin
        prio_nxt = frame_in.qos_prio;
        if (frame_in.msg == qcfg_pkg::MSG_EVENT && ev_ovr_r) begin
            prio_nxt = ev_prio_r;
        end else if (frame_in.msg == qcfg_pkg::MSG_NONEVENT && ne_ovr_r) begin
            prio_nxt = ne_prio_r;
        end
    end

    // code 01 must not be programmed; it folds like 10
    always_comb begin
        high_nxt = 1'b0;
        unique case (fold_r)
            qcfg_pkg::FOLD_ONE_HIGH:   high_nxt = (frame_in.regen_prio == 2'h3);
            qcfg_pkg::FOLD_UNUSED:     high_nxt = frame_in.regen_prio[1];
            qcfg_pkg::FOLD_HALF:       high_nxt = frame_in.regen_prio[1];
            qcfg_pkg::FOLD_THREE_HIGH: high_nxt = (frame_in.regen_prio != 2'h0);
        endcase
    end

    assign single = (frame_in.dest != '0) && ((frame_in.dest & (frame_in.dest - 1'b1)) == '0);

    always_comb begin
        fwd_nxt  = frame_in.dest & frame_in.member;
        drop_nxt = 1'b0;
        if (!disc_r && single) begin
            fwd_nxt  = frame_in.dest;
            drop_nxt = (frame_in.mirror & ~frame_in.dest) != '0;
        end
        if (drop_nxt) begin
            fwd_nxt = '0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            frame_out <= '0;
        end else begin
            frame_out.valid  <= frame_in.valid;
            frame_out.prio   <= prio_nxt;
            frame_out.high_q <= high_nxt;
            frame_out.fwd    <= fwd_nxt;
            frame_out.drop   <= frame_in.valid & drop_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    a_event_force: assert property (@(posedge clk_sys) disable iff (!arst_n)
        frame_in.valid && frame_in.msg == qcfg_pkg::MSG_EVENT && ev_ovr_r
        |=> frame_out.prio == $past(ev_prio_r)) else $error("event prio not forced");
    a_event_qos: assert property (@(posedge clk_sys) disable iff (!arst_n)
        frame_in.valid && frame_in.msg == qcfg_pkg::MSG_EVENT && !ev_ovr_r
        |=> frame_out.prio == $past(frame_in.qos_prio)) else $error("event prio changed");
    a_nonevent_force: assert property (@(posedge clk_sys) disable iff (!arst_n)
        frame_in.valid && frame_in.msg == qcfg_pkg::MSG_NONEVENT && ne_ovr_r
        |=> frame_out.prio == $past(ne_prio_r)) else $error("nonevent prio not forced");
    a_nonevent_qos: assert property (@(posedge clk_sys) disable iff (!arst_n)
        frame_in.valid && frame_in.msg == qcfg_pkg::MSG_NONEVENT && !ne_ovr_r
        |=> frame_out.prio == $past(frame_in.qos_prio)) else $error("nonevent prio changed");
    a_fold_one: assert property (@(posedge clk_sys) disable iff (!arst_n)
        frame_in.valid && fold_r == qcfg_pkg::FOLD_ONE_HIGH
        |=> frame_out.high_q == ($past(frame_in.regen_prio) == 2'h3)) else $error("fold 00 bad");
    a_fold_half: assert property (@(posedge clk_sys) disable iff (!arst_n)
        frame_in.valid && fold_r == qcfg_pkg::FOLD_HALF
        |=> frame_out.high_q == ($past(frame_in.regen_prio) >= 2'h2)) else $error("fold 10 bad");
    a_fold_three: assert property (@(posedge clk_sys) disable iff (!arst_n)
        frame_in.valid && fold_r == qcfg_pkg::FOLD_THREE_HIGH
        |=> frame_out.high_q == ($past(frame_in.regen_prio) != 2'h0)) else $error("fold 11 bad");
    a_member_limit: assert property (@(posedge clk_sys) disable iff (!arst_n)
        frame_in.valid && disc_r
        |=> (frame_out.fwd & ~$past(frame_in.member)) == '0) else $error("outside membership");
    a_single_free: assert property (@(posedge clk_sys) disable iff (!arst_n)
        frame_in.valid && !disc_r && single && frame_in.mirror == '0
        |=> frame_out.fwd == $past(frame_in.dest)) else $error("single dest limited");
    a_mirror_drop: assert property (@(posedge clk_sys) disable iff (!arst_n)
        frame_in.valid && !disc_r && single && (frame_in.mirror & ~frame_in.dest) != '0
        |=> frame_out.drop && frame_out.fwd == '0) else $error("mirrored frame kept");
    a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!arst_n)
        avs_read && !ack_r && idx == qcfg_pkg::IDX_EVENT
        |=> avs_readdata[6:4] == 3'h0 && avs_readdata[31:8] == 24'h0) else $error("reserved nonzero");
    a_bus_answer: assert property (@(posedge clk_sys) disable iff (!arst_n)
        acc && avs_waitrequest |=> !avs_waitrequest) else $error("answer late");

    // bus handshake: low for one cycle only, never without a request
    a_wait_pulse: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low too long");
    a_wait_idle: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !acc |=> avs_waitrequest) else $error("answer without request");
    a_ack_match: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ack_r == !avs_waitrequest) else $error("take flag and waitrequest disagree");
    a_read_unmapped: assert property (@(posedge clk_sys) disable iff (!arst_n)
        avs_read && !ack_r && !hit |=> avs_readdata == 32'h0) else $error("unmapped read");
    a_read_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !(avs_read && !ack_r) |=> $stable(avs_readdata)) else $error("readdata moved");
    a_read_load_once: assert property (@(posedge clk_sys) disable iff (!arst_n)
        avs_read && ack_r |=> $stable(avs_readdata)) else $error("readdata reloaded");

    // read-back paths and reserved fields
    a_colour_resv: assert property (@(posedge clk_sys) disable iff (!arst_n)
        avs_read && !ack_r && idx == qcfg_pkg::IDX_COLOUR
        |=> avs_readdata[31:6] == 26'h0) else $error("colour reserved nonzero");
    a_nonevent_resv: assert property (@(posedge clk_sys) disable iff (!arst_n)
        avs_read && !ack_r && idx == qcfg_pkg::IDX_NONEVENT
        |=> avs_readdata[6:4] == 3'h0 && avs_readdata[31:8] == 24'h0) else $error("ne resv");
    a_qmgmt_upper: assert property (@(posedge clk_sys) disable iff (!arst_n)
        avs_read && !ack_r && idx == qcfg_pkg::IDX_QMGMT
        |=> avs_readdata[31:8] == 24'h0) else $error("queue reserved nonzero");
    a_colour_readback: assert property (@(posedge clk_sys) disable iff (!arst_n)
        avs_read && !ack_r && idx == qcfg_pkg::IDX_COLOUR
        |=> avs_readdata[5:0] == $past({red_r, yellow_r, green_r})) else $error("colour rd");
    a_event_readback: assert property (@(posedge clk_sys) disable iff (!arst_n)
        avs_read && !ack_r && idx == qcfg_pkg::IDX_EVENT
        |=> avs_readdata[3:0] == $past(ev_prio_r)) else $error("event prio read");
    a_nonevent_readback: assert property (@(posedge clk_sys) disable iff (!arst_n)
        avs_read && !ack_r && idx == qcfg_pkg::IDX_NONEVENT
        |=> avs_readdata[3:0] == $past(ne_prio_r)) else $error("nonevent prio read");
    a_qmgmt_readback: assert property (@(posedge clk_sys) disable iff (!arst_n)
        avs_read && !ack_r && idx == qcfg_pkg::IDX_QMGMT
        |=> avs_readdata[7:6] == $past(fold_r)) else $error("fold code read");

    ////////////////////////////////////////////////////////////////////////////////
    // writes land only at the taking edge, lane 0, mapped address
    logic [23:0] cfg_bits;
    assign cfg_bits = {red_r, yellow_r, green_r, ev_ovr_r, ev_prio_r, ne_ovr_r, ne_prio_r,
                       fold_r, qres_r, disc_r, q0res_r};

    a_cfg_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !(wr_go && avs_byteenable[0] && hit) |=> $stable(cfg_bits)) else $error("stray write");
    a_colour_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
        wr_go && idx == qcfg_pkg::IDX_COLOUR && avs_byteenable[0]
        |=> {red_r, yellow_r, green_r} == $past(avs_writedata[5:0])) else $error("colour wr");
    a_event_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
        wr_go && idx == qcfg_pkg::IDX_EVENT && avs_byteenable[0]
        |=> ev_prio_r == $past(avs_writedata[3:0])) else $error("event prio write");
    a_nonevent_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
        wr_go && idx == qcfg_pkg::IDX_NONEVENT && avs_byteenable[0]
        |=> ne_prio_r == $past(avs_writedata[3:0])) else $error("nonevent prio write");
    a_fold_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
        wr_go && idx == qcfg_pkg::IDX_QMGMT && avs_byteenable[0]
        |=> fold_r == $past(avs_writedata[7:6])) else $error("fold code write");
    a_disc_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
        wr_go && idx == qcfg_pkg::IDX_QMGMT && avs_byteenable[0]
        |=> disc_r == $past(avs_writedata[1])) else $error("discard bit write");
    a_qres_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
        wr_go && idx == qcfg_pkg::IDX_QMGMT && avs_byteenable[0]
        |=> qres_r == $past(avs_writedata[5:2])) else $error("queue storage write");
    a_colour_out: assert property (@(posedge clk_sys) disable iff (!arst_n)
        colour_dscp == $past({red_r, yellow_r, green_r})) else $error("colour out stale");

    ////////////////////////////////////////////////////////////////////////////////
    // per-frame decision
    a_other_qos: assert property (@(posedge clk_sys) disable iff (!arst_n)
        frame_in.valid && frame_in.msg == qcfg_pkg::MSG_OTHER
        |=> frame_out.prio == $past(frame_in.qos_prio)) else $error("plain prio changed");
    a_nonevent_own: assert property (@(posedge clk_sys) disable iff (!arst_n)
        frame_in.valid && frame_in.msg == qcfg_pkg::MSG_NONEVENT && !ne_ovr_r && ev_ovr_r
        |=> frame_out.prio == $past(frame_in.qos_prio)) else $error("wrong override");
    a_fold_unused: assert property (@(posedge clk_sys) disable iff (!arst_n)
        frame_in.valid && fold_r == qcfg_pkg::FOLD_UNUSED
        |=> frame_out.high_q == $past(frame_in.regen_prio[1])) else $error("fold 01 bad");
    a_disc_limit: assert property (@(posedge clk_sys) disable iff (!arst_n)
        frame_in.valid && disc_r
        |=> frame_out.fwd == $past(frame_in.dest & frame_in.member)) else $error("disc fwd");
    a_multi_limit: assert property (@(posedge clk_sys) disable iff (!arst_n)
        frame_in.valid && !disc_r && !single
        |=> frame_out.fwd == $past(frame_in.dest & frame_in.member)) else $error("multi fwd");
    a_disc_no_drop: assert property (@(posedge clk_sys) disable iff (!arst_n)
        frame_in.valid && disc_r |=> !frame_out.drop) else $error("drop with discard set");
    a_multi_no_drop: assert property (@(posedge clk_sys) disable iff (!arst_n)
        frame_in.valid && !single |=> !frame_out.drop) else $error("multi dest dropped");
    a_mirror_keep: assert property (@(posedge clk_sys) disable iff (!arst_n)
        frame_in.valid && !disc_r && single && (frame_in.mirror & ~frame_in.dest) == '0
        |=> !frame_out.drop) else $error("unmirrored frame dropped");
    a_drop_empty: assert property (@(posedge clk_sys) disable iff (!arst_n)
        frame_out.drop |-> frame_out.valid && frame_out.fwd == '0) else $error("drop fwd");
    a_frame_valid: assert property (@(posedge clk_sys) disable iff (!arst_n)
        frame_in.valid |=> frame_out.valid) else $error("frame lost");
    a_frame_idle: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !frame_in.valid |=> !frame_out.valid && !frame_out.drop) else $error("phantom frame");

    c_event_force: cover property (@(posedge clk_sys) disable iff (!arst_n)
        frame_in.valid && frame_in.msg == qcfg_pkg::MSG_EVENT && ev_ovr_r);
    c_mirror_drop: cover property (@(posedge clk_sys) disable iff (!arst_n)
        frame_out.drop);
    c_fold_three: cover property (@(posedge clk_sys) disable iff (!arst_n)
        frame_in.valid && fold_r == qcfg_pkg::FOLD_THREE_HIGH);
    c_write_qmgmt: cover property (@(posedge clk_sys) disable iff (!arst_n)
        wr_go && idx == qcfg_pkg::IDX_QMGMT);
    c_fold_one: cover property (@(posedge clk_sys) disable iff (!arst_n)
        frame_in.valid && fold_r == qcfg_pkg::FOLD_ONE_HIGH);

endmodule : switch_queue_priority_config

// ### rtl/qcfg_pkg.sv
// Purpose: constants and carriers for the queue priority configuration bank
// Assumes: avalon-mm slave, 32-bit data, byte addresses
// Notes: register layout, reset values and frame carriers
package qcfg_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    localparam int ADDR_W = 12;
    localparam int PORTS  = 5;

    // register indices; printed offsets are not all word aligned
    localparam logic [11:0] IDX_COLOUR   = 12'h378;
    localparam logic [11:0] IDX_EVENT    = 12'h37c;
    localparam logic [11:0] IDX_NONEVENT = 12'h37d;
    localparam logic [11:0] IDX_QMGMT    = 12'h390;

    localparam int RED_LSB    = 4;
    localparam int YELLOW_LSB = 2;
    localparam int GREEN_LSB  = 0;
    localparam int OVR_BIT    = 7;
    localparam int FOLD_LSB   = 6;
    localparam int DISC_BIT   = 1;

    localparam logic [1:0] RED_RST    = 2'h3;
    localparam logic [1:0] YELLOW_RST = 2'h2;
    localparam logic [1:0] GREEN_RST  = 2'h1;
    localparam logic [3:0] PRIO_RST   = 4'hf;
    localparam logic       OVR_RST    = 1'h0;
    localparam logic [1:0] FOLD_RST   = 2'h2;
    localparam logic [3:0] QRES_RST   = 4'h0;
    localparam logic       DISC_RST   = 1'h1;
    localparam logic       Q0RES_RST  = 1'h0;

    localparam logic [1:0] FOLD_ONE_HIGH   = 2'h0;
    localparam logic [1:0] FOLD_UNUSED     = 2'h1;
    localparam logic [1:0] FOLD_HALF       = 2'h2;
    localparam logic [1:0] FOLD_THREE_HIGH = 2'h3;

    typedef enum logic [1:0] {
        MSG_OTHER    = 2'b00,
        MSG_EVENT    = 2'b01,
        MSG_NONEVENT = 2'b10
    } time_msg_t;

    typedef struct packed {
        logic             valid;
        time_msg_t        msg;
        logic [3:0]       qos_prio;
        logic [1:0]       regen_prio;
        logic [PORTS-1:0] dest;
        logic [PORTS-1:0] member;
        logic [PORTS-1:0] mirror;
    } frame_in_t;

    typedef struct packed {
        logic             valid;
        logic [3:0]       prio;
        logic             high_q;
        logic [PORTS-1:0] fwd;
        logic             drop;
    } frame_out_t;

endpackage : qcfg_pkg

// ### verif/tb.sv
// Purpose: self-checking bench for the queue priority configuration bank
// Assumes: slave answers each access within a few cycles, frame result one edge later
// Notes: drivers queue expected values, one monitor compares as results appear
`timescale 1ns/1ps
module tb;
    ////////////////////////////////////////////////////////////////////////////////
    logic                 clk_sys        = 1'b0;
    logic                 arst_n         = 1'b0;
    logic [11:0]          avs_address    = 12'h0;
    logic                 avs_read       = 1'b0;
    logic                 avs_write      = 1'b0;
    logic [31:0]          avs_writedata  = 32'h0;
    logic [3:0]           avs_byteenable = 4'hf;
    logic [31:0]          avs_readdata;
    logic                 avs_waitrequest;
    qcfg_pkg::frame_in_t  frame_in       = '0;
    qcfg_pkg::frame_out_t frame_out;
    logic [5:0]           colour_dscp;
    logic [31:0]          rd_q[$];
    qcfg_pkg::frame_out_t fr_q[$];
    logic [11:0]          addrs[5]       = '{12'h378, 12'h37c, 12'h37d, 12'h390, 12'h374};
    // shadow of the bank, starts at reset values
    logic [7:0]           col            = 8'h39;
    logic [7:0]           ev             = 8'h0f;
    logic [7:0]           ne             = 8'h0f;
    logic [7:0]           qm             = 8'h82;
    int                   n_mismatch     = 0;
    int                   checked        = 0;

    always #20 clk_sys = ~clk_sys;

    switch_queue_priority_config dut_u (
        .clk_sys        (clk_sys),
        .arst_n         (arst_n),
        .avs_address    (avs_address),
        .avs_read       (avs_read),
        .avs_write      (avs_write),
        .avs_writedata  (avs_writedata),
        .avs_byteenable (avs_byteenable),
        .avs_readdata   (avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .frame_in       (frame_in),
        .frame_out      (frame_out),
        .colour_dscp    (colour_dscp)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic cmp(input string what, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : cmp

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test

    function automatic logic [31:0] reg_val(input logic [11:0] a);
        case (a)
            12'h378: return {24'h0, col};
            12'h37c: return {24'h0, ev};
            12'h37d: return {24'h0, ne};
            12'h390: return {24'h0, qm};
            default: return 32'h0;
        endcase
    endfunction : reg_val

    // request held until waitrequest seen low at a rising edge
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        @(posedge clk_sys);
        avs_address    <= a;
        avs_read       <= ~w;
        avs_write      <= w;
        avs_writedata  <= d;
        avs_byteenable <= be;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
        bus(1'b1, a, d, be);
        if (be[0]) begin
            case (a)
                12'h378: col = {2'h0, d[5:0]};
                12'h37c: ev = {d[7], 3'h0, d[3:0]};
                12'h37d: ne = {d[7], 3'h0, d[3:0]};
                12'h390: qm = d[7:0];
                default: ;
            endcase
        end
    endtask : wr

    task automatic rd(input logic [11:0] a);
        rd_q.push_back(reg_val(a));
        bus(1'b0, a, $urandom, 4'hf);
    endtask : rd

    // expected decision worked out from the shadow registers
    task automatic send(input qcfg_pkg::frame_in_t f);
        qcfg_pkg::frame_out_t e;
        logic                 one;
        one     = $onehot(f.dest);
        e.valid = 1'b1;
        e.prio  = (f.msg == qcfg_pkg::MSG_EVENT && ev[7]) ? ev[3:0] :
                  (f.msg == qcfg_pkg::MSG_NONEVENT && ne[7]) ? ne[3:0] : f.qos_prio;
        case (qm[7:6])
            2'h0: e.high_q = (f.regen_prio == 2'h3);
            2'h3: e.high_q = (f.regen_prio != 2'h0);
            default: e.high_q = f.regen_prio[1];
        endcase
        e.drop = !qm[1] && one && |(f.mirror & ~f.dest);
        e.fwd  = e.drop ? 5'h0 : (!qm[1] && one) ? f.dest : (f.dest & f.member);
        if (f.valid) fr_q.push_back(e);
        @(posedge clk_sys);
        frame_in <= f;
    endtask : send

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_sys) begin
        if (avs_read && avs_waitrequest === 1'b0)
            cmp("readdata", avs_readdata, rd_q.size() ? rd_q.pop_front() : 32'hffff_ffff);
        if (frame_out.valid === 1'b1)
            cmp("frame", 32'(frame_out), fr_q.size() ? 32'(fr_q.pop_front()) : 32'h0);
    end

    // whole run needs well under this many cycles
    initial begin
        #(40 * 5000);
        n_mismatch++;
        finish_test();
    end

    initial begin
        qcfg_pkg::frame_in_t f;
        logic [31:0]         d;
        d = $urandom(32'hafc8e7c7);
        repeat (20) @(posedge clk_sys);
        arst_n <= 1'b1;
        foreach (addrs[i]) rd(addrs[i]);
        cmp("colour", {26'h0, colour_dscp}, 32'h39);
        $display("test reset_values done");
        foreach (addrs[i]) begin
            wr(addrs[i], $urandom, 4'hf);
            rd(addrs[i]);
        end
        wr(12'h378, 32'h0, 4'he); // lane 0 disabled: no change
        rd(12'h378);
        repeat (2) @(posedge clk_sys);
        cmp("colour", {26'h0, colour_dscp}, {26'h0, col[5:0]});
        $display("test register_access done");
        // fold code 01 must not be programmed, so only 00, 10, 11
        foreach (addrs[j]) begin
            if (j == 1 || j == 4) continue;
            for (int k = 0; k < 8; k++) begin
                d    = $urandom;
                d[7] = k[0];
                wr(12'h37c, d, 4'hf);
                d    = $urandom;
                d[7] = k[1];
                wr(12'h37d, d, 4'hf);
                wr(12'h390, {24'h0, 2'(j), 4'($urandom), k[2], 1'($urandom)}, 4'hf);
                rd(12'h390);
                repeat (12) begin
                    f.valid      = 1'b1;
                    f.msg        = qcfg_pkg::time_msg_t'(2'($urandom_range(2, 0)));
                    f.qos_prio   = 4'($urandom);
                    f.regen_prio = 2'($urandom);
                    f.dest       = $urandom_range(1, 0) ? 5'(1 << $urandom_range(4, 0))
                                                        : 5'($urandom);
                    f.member     = 5'($urandom);
                    f.mirror     = 5'($urandom);
                    send(f);
                end
                send('0);
            end
        end
        repeat (3) @(posedge clk_sys);
        cmp("frames left", 32'(fr_q.size()), 32'h0);
        $display("test frame_decision done");
        finish_test();
    end
endmodule : tb
